// ---- core/pfs_pin_mux.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Each select register holds sixteen 2-bit fields, lowest pin in 1:0, and code 00 means GPIO.
// - A GPIO direction bit acts on its pin only while the pin's field selects GPIO.
// - With any peripheral selected, the pin's output enable comes from that peripheral.
// - Port 1 GPIO direction comes from the legacy register, or from the fast one in fast mode.
// - Port 2 GPIO direction always comes from the fast direction register.
// - The port 0 high select register sits at 0xe002c004; its fields 13:12 up to 31:30 drive pins 22 to 31.
// - The port 1 low select register sits at 0xe002c008.
// - The port 1 high select register sits at 0xe002c00c.
// - The port 2 low select register sits at 0xe002c010.
// - Power-on or brown-out reset clears every select field so all pins start as GPIO.
// - Warm reset clears port 0, port 1 and port 2 pins 0 to 13; pins 14 and 15 keep on request.
module pfs_pin_mux (
   input  wire logic         clk,            // System clock, 250 MHz
   input  wire logic         rst,            // Power-on or brown-out reset
   input  wire logic         warmRst,        // External or watchdog reset
   input  wire logic [31:0]  address,        // Avalon byte address
   input  wire logic         read,           // Avalon read
   input  wire logic         write,          // Avalon write
   input  wire logic [31:0]  writedata,      // Avalon write data
   input  wire logic [3:0]   byteenable,     // Avalon byte enables
   output logic      [31:0]  readdata,       // Avalon read data
   output logic              waitrequest,    // Avalon wait request
   input  wire logic [9:0]   port0Dir,       // Port 0 pins 22..31 direction
   input  wire logic [31:0]  legacyPort1Dir, // Legacy port 1 direction
   input  wire logic [31:0]  fastPort1Dir,   // Fast port 1 direction
   input  wire logic [15:0]  fastPort2Dir,   // Fast port 2 direction, pins 0..15
   input  wire logic [57:0]  gpioOut,        // GPIO output values per pin
   output logic      [57:0]  gpioIn,         // Pad levels to GPIO
   input  wire logic [173:0] periphOut,      // Peripheral outputs, three per pin
   input  wire logic [173:0] periphOe,       // Peripheral output enables
   output logic      [173:0] periphIn,       // Pad levels to peripherals
   input  wire logic [57:0]  pinIn,          // Pad input levels
   output logic      [57:0]  pinOut,         // Pad output values
   output logic      [57:0]  pinOe           // Pad output enables
);
   typedef struct packed {
      logic         waitReq;
      logic [31:0]  rdData;
      logic         fastP1;
      logic         keepMem;
      logic [57:0]  gpioIn;
      logic [173:0] periphIn;
      logic [57:0]  pinOut;
      logic [57:0]  pinOe;
   } pfs_state_s;

   pfs_state_s q;
   pfs_state_s d;

   logic [31:0]  selReg [pfs_pkg::N_REGS];
   logic [127:0] selAll;
   logic [57:0]  dirVec;
   logic [57:0]  cellOut;
   logic [57:0]  cellOe;
   logic [173:0] cellIn;
   logic [57:0]  rsvVec;
   logic [63:0]  rsvSlots;
   logic [3:0]   rsvPerReg;
   logic [31:0]  wrMask;
   logic         wrCommit;
   logic         hitP0;
   logic         hitP1L;
   logic         hitP1H;
   logic         hitP2;
   logic         hitCtrl;
   logic         hitStat;
   logic [31:0]  rdMux;

   // Address decode against full byte addresses
   always_comb begin
      hitP0   = (address == pfs_pkg::ADDR_P0_HIGH_SEL);
      hitP1L  = (address == pfs_pkg::ADDR_P1_LOW_SEL);
      hitP1H  = (address == pfs_pkg::ADDR_P1_HIGH_SEL);
      hitP2   = (address == pfs_pkg::ADDR_P2_LOW_SEL);
      hitCtrl = (address == pfs_pkg::ADDR_GPIO_CTRL);
      hitStat = (address == pfs_pkg::ADDR_RSV_STATUS);
   end

   // Byte enables widen to a bit mask
   always_comb begin
      wrMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                {8{byteenable[1]}}, {8{byteenable[0]}}};
   end

   // A write lands only on the edge where the master sees waitrequest low
   assign wrCommit = write && !q.waitReq;

   // Select registers; only port 2 has fields that may survive warm reset
   pfs_sel_reg #(
      .WARM_CLEAR (pfs_pkg::WARM_ALL),
      .KEEP_ABLE  (pfs_pkg::WARM_NONE)
   ) u_selP0 (
      .clk        (clk),
      .rst        (rst),
      .warmRst    (warmRst),
      .keepOnWarm (q.keepMem),
      .wrEn       (wrCommit && hitP0),
      .wrMask     (wrMask),
      .wrData     (writedata),
      .value      (selReg[0])
   );

   pfs_sel_reg #(
      .WARM_CLEAR (pfs_pkg::WARM_ALL),
      .KEEP_ABLE  (pfs_pkg::WARM_NONE)
   ) u_selP1L (
      .clk        (clk),
      .rst        (rst),
      .warmRst    (warmRst),
      .keepOnWarm (q.keepMem),
      .wrEn       (wrCommit && hitP1L),
      .wrMask     (wrMask),
      .wrData     (writedata),
      .value      (selReg[1])
   );

   pfs_sel_reg #(
      .WARM_CLEAR (pfs_pkg::WARM_ALL),
      .KEEP_ABLE  (pfs_pkg::WARM_NONE)
   ) u_selP1H (
      .clk        (clk),
      .rst        (rst),
      .warmRst    (warmRst),
      .keepOnWarm (q.keepMem),
      .wrEn       (wrCommit && hitP1H),
      .wrMask     (wrMask),
      .wrData     (writedata),
      .value      (selReg[2])
   );

   // Port 2 pins 14 and 15 are shared with the memory interface
   pfs_sel_reg #(
      .WARM_CLEAR (pfs_pkg::WARM_P2_FIXED),
      .KEEP_ABLE  (pfs_pkg::WARM_P2_KEEP)
   ) u_selP2 (
      .clk        (clk),
      .rst        (rst),
      .warmRst    (warmRst),
      .keepOnWarm (q.keepMem),
      .wrEn       (wrCommit && hitP2),
      .wrMask     (wrMask),
      .wrData     (writedata),
      .value      (selReg[3])
   );

   assign selAll = {selReg[3], selReg[2], selReg[1], selReg[0]};

   // Port 0 fields 1:0..11:10 are stored but have no pin in this block
   assign rsvSlots[pfs_pkg::SLOT_BASE-1:0] = '0;

   // One cell per pin, slot s is field s of the four registers
   for (genvar s = pfs_pkg::SLOT_BASE; s < pfs_pkg::N_SLOTS; s++) begin : g_pin
      localparam int P = s - pfs_pkg::SLOT_BASE;

      // Direction source depends on the port
      if (s < pfs_pkg::P1_SLOT) begin : g_p0
         assign dirVec[P] = port0Dir[P];
      end else if (s < pfs_pkg::P2_SLOT) begin : g_p1
         assign dirVec[P] = q.fastP1 ? fastPort1Dir[s-pfs_pkg::P1_SLOT]
                                     : legacyPort1Dir[s-pfs_pkg::P1_SLOT];
      end else begin : g_p2
         assign dirVec[P] = fastPort2Dir[s-pfs_pkg::P2_SLOT];
      end

      pfs_pin_cell #(
         .RSV (pfs_pkg::RSV_TABLE[pfs_pkg::N_FN*s +: pfs_pkg::N_FN])
      ) u_cell (
         .sel       (selAll[pfs_pkg::FIELD_W*s +: pfs_pkg::FIELD_W]),
         .gpioDir   (dirVec[P]),
         .gpioOut   (gpioOut[P]),
         .periphOut (periphOut[pfs_pkg::N_FN*P +: pfs_pkg::N_FN]),
         .periphOe  (periphOe[pfs_pkg::N_FN*P +: pfs_pkg::N_FN]),
         .pinIn     (pinIn[P]),
         .pinOut    (cellOut[P]),
         .pinOe     (cellOe[P]),
         .periphIn  (cellIn[pfs_pkg::N_FN*P +: pfs_pkg::N_FN]),
         .rsvHit    (rsvVec[P])
      );

      assign rsvSlots[s] = rsvVec[P];
   end

   // One flag per register: some field holds a reserved code
   for (genvar r = 0; r < pfs_pkg::N_REGS; r++) begin : g_rsv
      assign rsvPerReg[r] = |rsvSlots[16*r +: 16];
   end

   // Read data selection; unmapped addresses read as zero
   always_comb begin
      rdMux = pfs_pkg::READ_ZERO;
      if (hitP0) begin
         rdMux = selReg[0];
      end else if (hitP1L) begin
         rdMux = selReg[1];
      end else if (hitP1H) begin
         rdMux = selReg[2];
      end else if (hitP2) begin
         rdMux = selReg[3];
      end else if (hitCtrl) begin
         rdMux[pfs_pkg::CTRL_FAST_P1_BIT]  = q.fastP1;
         rdMux[pfs_pkg::CTRL_KEEP_MEM_BIT] = q.keepMem;
      end else if (hitStat) begin
         rdMux[3:0] = rsvPerReg;
      end
   end

   // Bus handshake: one wait cycle, then waitrequest low for one cycle
   always_comb begin
      d = q;
      d.waitReq = 1'b1;
      if (q.waitReq && (read || write)) begin
         d.waitReq = 1'b0;
      end
      if (q.waitReq && read) begin
         d.rdData = rdMux;
      end
      // Control bits survive warm reset so keep is still known when it hits
      if (wrCommit && hitCtrl && byteenable[0]) begin
         d.fastP1  = writedata[pfs_pkg::CTRL_FAST_P1_BIT];
         d.keepMem = writedata[pfs_pkg::CTRL_KEEP_MEM_BIT];
      end
      // Pad and peripheral outputs cost one cycle of latency to come from flops
      d.pinOut   = cellOut;
      d.pinOe    = cellOe;
      d.periphIn = cellIn;
      d.gpioIn   = pinIn;
   end

   // Cold reset clears all state except waitReq, which it sets; pins come up as undriven GPIO
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '{waitReq: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign readdata    = q.rdData;
   assign waitrequest = q.waitReq;
   assign gpioIn      = q.gpioIn;
   assign periphIn    = q.periphIn;
   assign pinOut      = q.pinOut;
   assign pinOe       = q.pinOe;
endmodule

// ---- core/pfs_pkg.sv ----
// Shared constants for the pin function select block
package pfs_pkg;

   // Register byte addresses on the register bus
   localparam logic [31:0] ADDR_P0_HIGH_SEL = 32'he002c004;
   localparam logic [31:0] ADDR_P1_LOW_SEL  = 32'he002c008;
   localparam logic [31:0] ADDR_P1_HIGH_SEL = 32'he002c00c;
   localparam logic [31:0] ADDR_P2_LOW_SEL  = 32'he002c010;
   localparam logic [31:0] ADDR_GPIO_CTRL   = 32'he002c030;
   localparam logic [31:0] ADDR_RSV_STATUS  = 32'he002c034;

   // Control register fields
   localparam int CTRL_FAST_P1_BIT = 0;
   localparam int CTRL_KEEP_MEM_BIT = 1;

   // Reset values
   localparam logic [31:0] SEL_RESET   = 32'h00000000;
   localparam logic [31:0] READ_ZERO   = 32'h00000000;

   // Warm reset clears these bits always; the keep-able bits only without keep
   localparam logic [31:0] WARM_ALL      = 32'hffffffff;
   localparam logic [31:0] WARM_P2_FIXED = 32'h0fffffff;
   localparam logic [31:0] WARM_P2_KEEP  = 32'hf0000000;
   localparam logic [31:0] WARM_NONE     = 32'h00000000;

   // Field layout
   localparam int FIELD_W    = 2;
   localparam int N_FN       = 3;
   localparam int N_REGS     = 4;
   localparam int N_SLOTS    = 64;
   localparam int SLOT_BASE  = 6;
   localparam int N_PINS     = 58;
   localparam int P1_SLOT    = 16;
   localparam int P2_SLOT    = 48;
   localparam logic [1:0] CODE_GPIO = 2'h0;

   // Per-slot reserved codes, bit order {code 11, code 10, code 01}
   localparam logic [2:0] RS = 3'h6;
   localparam logic [2:0] NO = 3'h0;
   localparam logic [191:0] RSV_TABLE = {
      NO, NO, NO, NO, NO, RS, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO,
      NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, RS, RS,
      RS, RS, RS, NO, NO, RS, RS, RS, NO, NO, NO, RS, NO, NO, RS, RS,
      RS, RS, RS, RS, RS, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO, NO
   };

endpackage

// ---- core/pfs_sel_reg.sv ----
`timescale 1ns/1ps
// One 32-bit function select register with cold and warm reset classes
module pfs_sel_reg #(
   parameter logic [31:0] WARM_CLEAR = 32'hffffffff,
   parameter logic [31:0] KEEP_ABLE  = 32'h00000000
) (
   input  wire logic        clk,        // System clock
   input  wire logic        rst,        // Power-on or brown-out reset
   input  wire logic        warmRst,    // External or watchdog reset
   input  wire logic        keepOnWarm, // Keep memory pin fields on warm reset
   input  wire logic        wrEn,       // Write commit
   input  wire logic [31:0] wrMask,     // Bit mask from byte enables
   input  wire logic [31:0] wrData,     // Write data
   output logic      [31:0] value       // Stored fields
);
   typedef struct packed {
      logic [31:0] val;
   } pfs_selreg_s;

   pfs_selreg_s q;
   pfs_selreg_s d;

   // Warm reset beats a write in the same cycle
   always_comb begin
      d = q;
      if (warmRst) begin
         d.val = q.val & ~(WARM_CLEAR | (keepOnWarm ? pfs_pkg::WARM_NONE : KEEP_ABLE));
      end else if (wrEn) begin
         d.val = (q.val & ~wrMask) | (wrData & wrMask);
      end
   end

   // Cold reset clears every field
   always_ff @(posedge clk) begin
      if (rst) begin
         q.val <= pfs_pkg::SEL_RESET;
      end else begin
         q <= d;
      end
   end

   assign value = q.val;
endmodule

// ---- core/pfs_pin_cell.sv ----
`timescale 1ns/1ps
// Routing for one pin between GPIO and up to three peripheral signals
module pfs_pin_cell #(
   parameter logic [2:0] RSV = 3'h0
) (
   input  wire logic [1:0] sel,       // Function select field
   input  wire logic       gpioDir,   // Effective GPIO direction, 1 = output
   input  wire logic       gpioOut,   // GPIO output value
   input  wire logic [2:0] periphOut, // Peripheral outputs for codes 01..11
   input  wire logic [2:0] periphOe,  // Peripheral output enables
   input  wire logic       pinIn,     // Pad input level
   output logic            pinOut,    // Pad output value
   output logic            pinOe,     // Pad output enable
   output logic      [2:0] periphIn,  // Pad level to the selected peripheral
   output logic            rsvHit     // Field holds a reserved code
);
   logic [1:0] idx;

   // Reserved codes leave the pin undriven and disconnected
   always_comb begin
      idx      = sel - 2'h1;
      pinOut   = 1'b0;
      pinOe    = 1'b0;
      periphIn = 3'h0;
      rsvHit   = 1'b0;
      if (sel == pfs_pkg::CODE_GPIO) begin
         pinOut = gpioOut;
         pinOe  = gpioDir;
      end else if (RSV[idx]) begin
         rsvHit = 1'b1;
      end else begin
         pinOut        = periphOut[idx];
         pinOe         = periphOe[idx];
         periphIn[idx] = pinIn;
      end
   end
endmodule

// ---- verif/pfs_pin_mux_properties.sv ----
`timescale 1ns/1ps
// Bus timing and routing of sample pins P1[0], P1[2] and P2[0]
module pfs_pin_mux_properties (
   input wire logic         clk,            // Clock
   input wire logic         rst,            // Cold reset
   input wire logic         warmRst,        // Warm reset
   input wire logic [31:0]  address,        // Bus address
   input wire logic         read,           // Bus read
   input wire logic         write,          // Bus write
   input wire logic [31:0]  writedata,      // Bus data
   input wire logic [3:0]   byteenable,     // Byte lanes
   input wire logic         waitrequest,    // Bus stall
   input wire logic [31:0]  legacyPort1Dir, // Legacy dir
   input wire logic [31:0]  fastPort1Dir,   // Fast dir
   input wire logic [15:0]  fastPort2Dir,   // Port 2 dir
   input wire logic [173:0] periphOe,       // Periph enables
   input wire logic [173:0] periphIn,       // Periph inputs
   input wire logic [57:0]  pinIn,          // Pad levels
   input wire logic [57:0]  pinOut,         // Pad values
   input wire logic [57:0]  pinOe           // Pad enables
);
   logic [31:0] p1Sel_q, p2Sel_q, beMask;
   logic [1:0]  ctrl_q, age_q;
   logic [2:0]  inExp;
   logic        wrHit, settled, oeSel;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Shadows of the registers steering the watched pins
   assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wrHit = write && !waitrequest;
   assign settled = age_q == 2'h3;
   assign oeSel = periphOe[35 + p1Sel_q[5:4]];
   assign inExp = p1Sel_q[5:4] == 2'h0 ? 3'h0 : {3{pinIn[12]}} & (3'h1 << (p1Sel_q[5:4] - 2'h1));
   always_ff @(posedge clk) begin
      if (rst) begin
         p1Sel_q <= 32'h0;
         p2Sel_q <= 32'h0;
         ctrl_q <= 2'h0;
         age_q <= 2'h0;
      end else begin
         age_q <= settled ? age_q : age_q + 2'h1;
         if (wrHit && address == pfs_pkg::ADDR_GPIO_CTRL && byteenable[0])
            ctrl_q <= writedata[1:0];
         // Warm reset wins over a write in the same cycle
         if (warmRst) begin
            p1Sel_q <= 32'h0;
            p2Sel_q <= ctrl_q[1] ? p2Sel_q & pfs_pkg::WARM_P2_KEEP : 32'h0;
         end else if (wrHit && address == pfs_pkg::ADDR_P1_LOW_SEL)
            p1Sel_q <= p1Sel_q & ~beMask | writedata & beMask;
         else if (wrHit && address == pfs_pkg::ADDR_P2_LOW_SEL)
            p2Sel_q <= p2Sel_q & ~beMask | writedata & beMask;
      end
   end
   a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait state not one cycle");
   a_wait_release: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   a_cold_clear: assert property (disable iff (1'b0) rst |=>
      pinOe == 58'h0 && waitrequest) else $error("cold reset left pins driven");
   a_p1_dir_src: assert property (settled && $past(p1Sel_q[5:4]) == 2'h0 |->
      pinOe[12] == ($past(ctrl_q[0]) ? $past(fastPort1Dir[2]) : $past(legacyPort1Dir[2])))
      else $error("port 1 direction source wrong");
   a_p2_dir_src: assert property (settled && $past(p2Sel_q[1:0]) == 2'h0 |->
      pinOe[42] == $past(fastPort2Dir[0])) else $error("port 2 direction source wrong");
   a_periph_oe: assert property (settled && $past(p1Sel_q[5:4]) != 2'h0 |->
      pinOe[12] == $past(oeSel)) else $error("peripheral enable not routed");
   a_periph_in: assert property (settled |-> periphIn[38:36] == $past(inExp))
      else $error("peripheral input routing wrong");
   a_rsv_float: assert property (settled && $past(p1Sel_q[1]) |->
      !pinOe[10] && !pinOut[10]) else $error("reserved code drives pin");
   c_p1_write: cover property (wrHit && address == pfs_pkg::ADDR_P1_LOW_SEL);
   c_warm_keep: cover property (warmRst && ctrl_q[1]);
   c_code_three: cover property (settled && p1Sel_q[5:4] == 2'h3);
endmodule

bind pfs_pin_mux pfs_pin_mux_properties pfs_props_inst (.clk, .rst, .warmRst, .address, .read,
   .write, .writedata, .byteenable, .waitrequest, .legacyPort1Dir, .fastPort1Dir, .fastPort2Dir,
   .periphOe, .periphIn, .pinIn, .pinOut, .pinOe);

// ---- verif/pfs_pin_mux_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the pin function select block
module pfs_pin_mux_tb;
   logic         clk = 1'b0, rst = 1'b1, warmRst = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
   logic [31:0]  address = 32'h0, writedata = 32'h0, readdata, rd;
   logic [31:0]  legacyPort1Dir = 32'h0, fastPort1Dir = 32'h0;
   logic [3:0]   byteenable = 4'hf;
   logic [9:0]   port0Dir = 10'h0;
   logic [15:0]  fastPort2Dir = 16'h0;
   logic [57:0]  gpioOut = 58'h0, pinIn = 58'h0, gpioIn, pinOut, pinOe;
   logic [173:0] periphOut = 174'h0, periphOe = 174'h0, periphIn;
   int           failCount = 0, nCompared = 0, cycles = 0;

   pfs_pin_mux pfs_pin_mux_inst (.clk, .rst, .warmRst, .address, .read, .write, .writedata,
      .byteenable, .readdata, .waitrequest, .port0Dir, .legacyPort1Dir, .fastPort1Dir,
      .fastPort2Dir, .gpioOut, .gpioIn, .periphOut, .periphOe, .periphIn, .pinIn, .pinOut, .pinOe);

   always #2 clk = ~clk;
   // Ends the run after 5000 cycles; bus already gives up on a hung handshake after 50
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         failCount++;
         tallyAndFinish();
      end
   end

   task automatic tallyAndFinish();
      if (failCount == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus access, held until waitrequest is seen low
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         failCount++;
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hf);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0, 4'hf);
      check(rd, exp);
   endtask

   // Pads lag their cause by one register stage
   task automatic pins(input int p, input logic oe, input logic out);
      repeat (3) @(posedge clk);
      check(32'({pinOe[p], pinOut[p]}), 32'({oe, out}));
   endtask

   task automatic check_reset();
      for (int i = 0; i < 4; i++)
         rdchk(pfs_pkg::ADDR_P0_HIGH_SEL + 32'(4 * i), 32'h0);
      check(pinOe[31:0], 32'h0);
   endtask

   task automatic check_map();
      for (int i = 0; i < 4; i++)
         wr(pfs_pkg::ADDR_P0_HIGH_SEL + 32'(4 * i), 32'h13572468 + 32'(i));
      // Each register read back at its own address, so a swapped decode shows
      rdchk(pfs_pkg::ADDR_P0_HIGH_SEL, 32'h13572468);
      rdchk(pfs_pkg::ADDR_P1_LOW_SEL, 32'h13572469);
      rdchk(pfs_pkg::ADDR_P1_HIGH_SEL, 32'h1357246a);
      rdchk(pfs_pkg::ADDR_P2_LOW_SEL, 32'h1357246b);
      bus(pfs_pkg::ADDR_P0_HIGH_SEL, 1'b1, 32'hffffffff, 4'h2);
      rdchk(pfs_pkg::ADDR_P0_HIGH_SEL, 32'h1357ff68);
      wr(32'he002c020, 32'hffffffff);
      rdchk(32'he002c020, 32'h0);
      for (int i = 0; i < 4; i++)
         wr(pfs_pkg::ADDR_P0_HIGH_SEL + 32'(4 * i), 32'h0);
   endtask

   // Field 11:10 holds code 10 so a shifted decode would show
   task automatic check_port0();
      {periphOe[0], periphOut[0], port0Dir[1], gpioOut[1]} <= 4'hf;
      wr(pfs_pkg::ADDR_P0_HIGH_SEL, 32'h1800);
      pins(0, 1'b1, 1'b1);
      pins(1, 1'b1, 1'b1);
      wr(pfs_pkg::ADDR_P0_HIGH_SEL, 32'h0);
   endtask

   task automatic check_p1_dir();
      {legacyPort1Dir[2], fastPort1Dir[2], gpioOut[12]} <= 3'h5;
      pins(12, 1'b1, 1'b1);
      wr(pfs_pkg::ADDR_GPIO_CTRL, 32'h1);
      rdchk(pfs_pkg::ADDR_GPIO_CTRL, 32'h1);
      pins(12, 1'b0, 1'b1);
      wr(pfs_pkg::ADDR_GPIO_CTRL, 32'h0);
   endtask

   // Direction stays 1 so code 10 proves it is ignored
   task automatic check_periph();
      {periphOe[38:36], periphOut[38:36], pinIn[12]} <= 7'h57;
      for (int c = 1; c < 4; c++) begin
         wr(pfs_pkg::ADDR_P1_LOW_SEL, 32'(c) << 4);
         pins(12, c != 2, c != 3);
         check(32'(periphIn[38:36]), 32'(1) << (c - 1));
      end
      check(32'(gpioIn[12]), 32'h1);
      wr(pfs_pkg::ADDR_P1_LOW_SEL, 32'h0);
   endtask

   task automatic check_p2_dir();
      // Legacy bit always opposes the fast bit, so a wrong source shows
      {fastPort2Dir[0], legacyPort1Dir[0], gpioOut[42]} <= 3'h5;
      pins(42, 1'b1, 1'b1);
      {fastPort2Dir[0], legacyPort1Dir[0]} <= 2'h1;
      pins(42, 1'b0, 1'b1);
   endtask

   task automatic check_reserved();
      {periphOe[32:30], periphOut[32:30]} <= 6'h3f;
      wr(pfs_pkg::ADDR_P1_LOW_SEL, 32'h1);
      pins(10, 1'b1, 1'b1);
      wr(pfs_pkg::ADDR_P1_LOW_SEL, 32'h2);
      pins(10, 1'b0, 1'b0);
      rdchk(pfs_pkg::ADDR_P1_LOW_SEL, 32'h2);
      // Only the port 1 low register holds a reserved code now
      rdchk(pfs_pkg::ADDR_RSV_STATUS, 32'h2);
   endtask

   // First pass keeps the upper port 2 fields, second clears all
   task automatic check_warm();
      for (int k = 0; k < 2; k++) begin
         wr(pfs_pkg::ADDR_GPIO_CTRL, 32'(2 - 2 * k));
         wr(pfs_pkg::ADDR_P0_HIGH_SEL, 32'hffffffff);
         wr(pfs_pkg::ADDR_P2_LOW_SEL, 32'hffffffff);
         @(posedge clk);
         warmRst <= 1'b1;
         @(posedge clk);
         warmRst <= 1'b0;
         rdchk(pfs_pkg::ADDR_P0_HIGH_SEL, 32'h0);
         rdchk(pfs_pkg::ADDR_P1_LOW_SEL, 32'h0);
         rdchk(pfs_pkg::ADDR_P2_LOW_SEL, k == 0 ? 32'hf0000000 : 32'h0);
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      check_reset();
      check_map();
      check_port0();
      check_p1_dir();
      check_periph();
      check_p2_dir();
      check_reserved();
      check_warm();
      tallyAndFinish();
   end
endmodule
